/* File: design/mii_phy_port.sv */
// nibble-wide data port of the transceiver, facing the mac
`timescale 1ns/1ps
module mii_phy_port #(
  parameter int unsigned JABBER_CYC = mii_pkg::JABBER_CYC, // lockout threshold
  parameter int unsigned RELEASE_CYC = mii_pkg::RELEASE_CYC // lockout release time
) (
  input wire logic sys_clk_in, // 100 mhz system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic ce_in, // clock enable
  input wire logic [2:0] cfg_strap_in, // configuration strap pins
  input wire logic speed_100_in, // 1 = 100 mbps, 0 = 10 mbps
  input wire logic full_duplex_in, // 1 = full duplex
  input wire logic link_up_in, // line link status
  output logic mii_mode_out, // nibble mode chosen by straps
  output logic txc_out, // transmit clock to mac
  input wire logic tx_en_in, // transmit enable pin from mac
  input wire logic [3:0] txd_in, // transmit data pins from mac
  output logic [7:0] tx_byte_out, // assembled transmit byte to line coder
  output logic tx_byte_valid_out, // one-cycle strobe for tx_byte_out
  input wire logic rec_clk_in, // clock recovered from the line
  input wire logic [7:0] rx_byte_in, // decoded receive byte from line
  input wire logic rx_byte_valid_in, // receive byte offered
  output logic rx_byte_ready_out, // port can take a receive byte this cycle
  input wire logic rx_sos_in, // start of stream / valid preamble seen
  input wire logic rx_eos_in, // end of stream / end marker seen
  input wire logic rx_idle_in, // idle symbols seen
  input wire logic rx_code_err_in, // symbol or coding error pulse
  output logic rxc_out, // receive clock to mac
  output logic rxdv_out, // receive data valid
  output logic [3:0] rxd_out, // receive data
  output logic rxer_out, // receive error
  output logic crs_out, // carrier sense
  output logic col_out // collision
);
  logic [2:0] cfg_s1, cfg_s2; // strap synchroniser
  logic strap_done_r; // straps captured since reset
  logic mii_sel_r; // nibble mode selected
  logic txen_s1, txen_s2; // transmit enable synchroniser
  logic [3:0] txd_s1, txd_s2; // transmit data synchroniser
  logic rec_s1, rec_s2; // recovered clock synchroniser
  logic ref_clk, ref_rise; // local reference port clock
  logic [5:0] half_sel; // half period for the current speed
  logic tx_act_r; // transmit enable seen at last clock edge
  logic tx_half_r; // low nibble held
  logic [3:0] tx_low_r; // held low nibble
  logic jab_r; // jabber lockout active
  logic [mii_pkg::CNT_W-1:0] jab_cnt_r; // jabber / release timer
  logic [mii_pkg::SQE_W-1:0] sqe_cnt_r; // heartbeat pulse timer
  logic rxc_prev_r; // receive clock one cycle ago
  logic rx_fall; // receive clock falling edge
  logic use_rec; // receive clock follows the line
  logic rx_have_r; // receive byte held
  logic [7:0] rx_byte_r; // held receive byte
  logic rx_half_r; // low nibble already presented
  logic err_pend_r; // error waiting for next nibble
  logic present, consume; // drive a nibble / free the held byte
  logic [3:0] nib; // nibble to drive
  mii_pkg::rx_state_e rx_st_r, rx_st_nxt; // receive framing state

  // strap synchroniser keeps sampling through reset, so the capture at
  // release sees the pins and not a cleared flop
  always_ff @(posedge sys_clk_in) begin
    if (ce_in) begin
      cfg_s1 <= cfg_strap_in;
      cfg_s2 <= cfg_s1;
    end
  end

  // two-stage synchronisers for the other pins from outside the domain
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      txen_s1 <= 1'b0;
      txen_s2 <= 1'b0;
      txd_s1 <= '0;
      txd_s2 <= '0;
      rec_s1 <= 1'b0;
      rec_s2 <= 1'b0;
    end else if (ce_in) begin
      txen_s1 <= tx_en_in;
      txen_s2 <= txen_s1;
      txd_s1 <= txd_in;
      txd_s2 <= txd_s1;
      rec_s1 <= rec_clk_in;
      rec_s2 <= rec_s1;
    end
  end

  // capture the straps once after reset release
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      strap_done_r <= 1'b0;
      mii_sel_r <= 1'b0;
    end else if (ce_in && !strap_done_r) begin
      strap_done_r <= 1'b1;
      mii_sel_r <= (cfg_s2 == mii_pkg::CFG_NIBBLE);
    end
  end
  assign mii_mode_out = mii_sel_r;

  a_strap_select: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(strap_done_r) |-> mii_sel_r == ($past(cfg_s2) == 3'h0))
    else $error("strap selection wrong");

  // free-running reference clock, rate by speed
  assign half_sel = speed_100_in ? mii_pkg::HALF_FAST : mii_pkg::HALF_SLOW;
  clk_div #(.W(mii_pkg::HALF_W)) u_ref_div (
    .sys_clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .half_in(half_sel),
    .clk_out(ref_clk),
    .rise_out(ref_rise),
    .fall_out()
  );
  assign txc_out = ref_clk;

  a_txc_fast_period: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(txc_out) ##1 (speed_100_in && ce_in)[*4] |-> $rose(txc_out))
    else $error("transmit clock period wrong at 100 mbps");

  // take nibbles at the transmit clock rise, pair them low first
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      tx_act_r <= 1'b0;
      tx_half_r <= 1'b0;
      tx_low_r <= '0;
      tx_byte_out <= '0;
      tx_byte_valid_out <= 1'b0;
    end else if (ce_in) begin
      tx_byte_valid_out <= 1'b0;
      if (ref_rise) begin
        tx_act_r <= txen_s2 && mii_sel_r;
        if (txen_s2 && mii_sel_r && !jab_r) begin
          if (!tx_half_r) begin
            tx_low_r <= txd_s2;
            tx_half_r <= 1'b1;
          end else begin
            tx_byte_out <= {txd_s2, tx_low_r};
            tx_byte_valid_out <= 1'b1;
            tx_half_r <= 1'b0;
          end
        end else begin
          tx_half_r <= 1'b0; // idle: data ignored, odd nibble dropped
        end
      end
    end
  end

  a_tx_only_enabled: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tx_byte_valid_out |-> $past(txen_s2) && !$past(jab_r))
    else $error("byte taken while transmit enable low");

  // jabber lockout timer, 10 mbps only
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      jab_r <= 1'b0;
      jab_cnt_r <= '0;
    end else if (ce_in) begin
      if (speed_100_in) begin
        jab_r <= 1'b0;
        jab_cnt_r <= '0;
      end else if (!jab_r) begin
        if (!txen_s2) begin
          jab_cnt_r <= '0;
        end else if (jab_cnt_r >= mii_pkg::CNT_W'(JABBER_CYC - 1)) begin
          jab_r <= 1'b1;
          jab_cnt_r <= '0;
        end else begin
          jab_cnt_r <= jab_cnt_r + 1'b1;
        end
      end else begin
        if (txen_s2) begin
          jab_cnt_r <= '0;
        end else if (jab_cnt_r >= mii_pkg::CNT_W'(RELEASE_CYC - 1)) begin
          jab_r <= 1'b0;
          jab_cnt_r <= '0;
        end else begin
          jab_cnt_r <= jab_cnt_r + 1'b1;
        end
      end
    end
  end

  // heartbeat pulse after each 10 mbps frame, collision output
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      sqe_cnt_r <= '0;
      col_out <= 1'b0;
    end else if (ce_in) begin
      if (ref_rise && tx_act_r && !txen_s2 && !speed_100_in) begin
        sqe_cnt_r <= mii_pkg::SQE_W'(mii_pkg::SQE_CYC);
      end else if (sqe_cnt_r != '0) begin
        sqe_cnt_r <= sqe_cnt_r - 1'b1;
      end
      col_out <= jab_r || (sqe_cnt_r != '0) ||
        (!full_duplex_in && tx_act_r && crs_out);
    end
  end

  a_jabber_holds_col: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (jab_r && ce_in) |=> col_out)
    else $error("collision not held during jabber");
  a_half_duplex_col: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!full_duplex_in && tx_act_r && crs_out && ce_in) |=> col_out)
    else $error("collision missed in half duplex");

  // carrier sense: start wins over end in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      crs_out <= 1'b0;
    end else if (ce_in) begin
      if (rx_sos_in && mii_sel_r) begin
        crs_out <= 1'b1;
      end else if (rx_eos_in || (speed_100_in && rx_idle_in)) begin
        crs_out <= 1'b0;
      end
    end
  end

  a_crs_idle_drop: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (speed_100_in && rx_idle_in && !rx_sos_in && ce_in) |=> !crs_out)
    else $error("carrier kept after idle symbols");

  // receive clock: line clock or local reference by mode
  assign use_rec = speed_100_in ? link_up_in : crs_out;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rxc_out <= 1'b0;
      rxc_prev_r <= 1'b0;
    end else if (ce_in) begin
      rxc_out <= use_rec ? rec_s2 : ref_clk;
      rxc_prev_r <= rxc_out;
    end
  end
  assign rx_fall = ce_in && rxc_prev_r && !rxc_out;

  a_rxc_ref_idle: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (!speed_100_in && !crs_out && ce_in) |=> rxc_out == $past(ref_clk))
    else $error("receive clock not on reference while idle");

  // framing decision at each receive clock fall
  always_comb begin
    rx_st_nxt = rx_st_r;
    present = 1'b0;
    consume = 1'b0;
    nib = rx_half_r ? rx_byte_r[7:4] : rx_byte_r[3:0];
    if (rx_fall) begin
      case (rx_st_r)
        mii_pkg::RX_IDLE: begin
          if (rx_have_r) begin
            rx_st_nxt = speed_100_in ? mii_pkg::RX_DATA : mii_pkg::RX_HUNT;
            present = speed_100_in;
          end
        end
        mii_pkg::RX_HUNT: begin
          if (rx_have_r && rx_byte_r == mii_pkg::SFD_BYTE) begin
            rx_st_nxt = mii_pkg::RX_DATA;
            present = 1'b1;
          end else if (rx_have_r) begin
            consume = 1'b1; // preamble not shown at 10 mbps
          end else if (!crs_out) begin
            rx_st_nxt = mii_pkg::RX_IDLE;
          end
        end
        mii_pkg::RX_DATA: begin
          if (rx_have_r) begin
            present = 1'b1;
          end else begin
            rx_st_nxt = mii_pkg::RX_IDLE; // frame over
          end
        end
        default: rx_st_nxt = mii_pkg::RX_IDLE;
      endcase
      if (present && rx_half_r) begin
        consume = 1'b1;
      end
    end
  end

  // one-byte hold register toward the line decoder
  assign rx_byte_ready_out = ce_in && mii_sel_r && !rx_have_r;
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rx_have_r <= 1'b0;
      rx_byte_r <= '0;
    end else if (rx_byte_valid_in && rx_byte_ready_out) begin
      rx_have_r <= 1'b1;
      rx_byte_r <= rx_byte_in;
    end else if (consume) begin
      rx_have_r <= 1'b0;
    end
  end

  // receive outputs, changed only at the receive clock fall
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      rx_st_r <= mii_pkg::RX_IDLE;
      rx_half_r <= 1'b0;
      rxdv_out <= 1'b0;
      rxd_out <= mii_pkg::IDLE_NIB;
      rxer_out <= 1'b0;
    end else if (rx_fall) begin
      rx_st_r <= rx_st_nxt;
      rxdv_out <= present;
      rxd_out <= present ? nib : mii_pkg::IDLE_NIB;
      rxer_out <= present && (err_pend_r || rx_code_err_in);
      rx_half_r <= present ? !rx_half_r : 1'b0;
    end
  end

  // error pending until a nibble carries it; a new error wins over the clear
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      err_pend_r <= 1'b0;
    end else if (ce_in) begin
      if (rx_code_err_in) begin
        err_pend_r <= 1'b1;
      end else if (rx_fall && present) begin
        err_pend_r <= 1'b0;
      end
    end
  end

  a_rxdv_on_sfd: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    ($rose(rxdv_out) && !speed_100_in) |-> rxd_out == 4'h5)
    else $error("10 mbps valid did not start on delimiter");
  a_rx_outputs_on_fall: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    ($changed(rxd_out) || $changed(rxdv_out)) |-> $past(rx_fall))
    else $error("receive outputs moved off the clock fall");
  a_rx_high_follows_low: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (rx_fall && present && !rx_half_r) |=> rxd_out == $past(rx_byte_r[3:0]))
    else $error("low nibble not first");
endmodule

/* File: design/mii_pkg.sv */
// constants and types shared by the nibble-wide mac-facing data port
package mii_pkg;
  localparam int unsigned SYS_CLK_HZ = 100_000_000; // system clock rate
  localparam int unsigned CLK_FAST_HZ = 25_000_000; // port clock at 100 mbps
  localparam int unsigned CLK_SLOW_HZ = 2_500_000; // port clock at 10 mbps
  localparam int unsigned HALF_W = 6; // width of half-period counts
  localparam logic [5:0] HALF_FAST = 6'(SYS_CLK_HZ / (2 * CLK_FAST_HZ)); // 2 cycles
  localparam logic [5:0] HALF_SLOW = 6'(SYS_CLK_HZ / (2 * CLK_SLOW_HZ)); // 20 cycles
  localparam int unsigned JABBER_MS = 20; // longest transmit enable before lockout
  localparam int unsigned RELEASE_MS = 250; // quiet time that ends the lockout
  localparam int unsigned JABBER_CYC = (SYS_CLK_HZ / 1000) * JABBER_MS;
  localparam int unsigned RELEASE_CYC = (SYS_CLK_HZ / 1000) * RELEASE_MS;
  localparam int unsigned SQE_NS = 1000; // heartbeat collision pulse length
  localparam int unsigned SQE_CYC = (SQE_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned CNT_W = 25; // wide enough for the release count
  localparam int unsigned SQE_W = 8; // heartbeat counter width
  localparam int unsigned CFG_W = 3; // strap width
  localparam logic [2:0] CFG_NIBBLE = 3'h0; // strap code of nibble mode
  localparam int unsigned NIB_W = 4; // nibble width
  localparam logic [7:0] SFD_BYTE = 8'hd5; // delimiter byte, nibbles 5 then d
  localparam logic [3:0] IDLE_NIB = 4'h0; // receive data while not valid
  // receive framing states
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_HUNT = 3'b010,
    RX_DATA = 3'b100
  } rx_state_e;
endpackage

/* File: design/clk_div.sv */
// divider that makes a square port clock with edge pulses
`timescale 1ns/1ps
module clk_div #(
  parameter int unsigned W = 6 // half-period counter width
) (
  input wire logic sys_clk_in, // system clock
  input wire logic nrst_in, // synchronous reset, active low
  input wire logic ce_in, // clock enable, freezes state when low
  input wire logic [W-1:0] half_in, // half period in system cycles
  output logic clk_out, // divided clock level
  output logic rise_out, // high in the cycle clk_out became 1
  output logic fall_out // high in the cycle clk_out became 0
);
  logic [W-1:0] cnt_r; // cycles spent in this half period

  // count half periods and toggle; >= keeps a speed change from overrunning
  always_ff @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cnt_r <= '0;
      clk_out <= 1'b0;
      rise_out <= 1'b0;
      fall_out <= 1'b0;
    end else if (ce_in) begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      if (cnt_r >= half_in - W'(1)) begin
        cnt_r <= '0;
        clk_out <= ~clk_out;
        rise_out <= ~clk_out;
        fall_out <= clk_out;
      end else begin
        cnt_r <= cnt_r + W'(1);
      end
    end
  end
endmodule

/* File: bench/mac_model.sv */
// mac model: drives transmit nibbles on txc and gathers receive bytes on rxc
`timescale 1ns/1ps
module mac_model (
  input wire logic sys_clk_in, // clock used to spot port clock edges
  input wire logic txc_in, // transmit clock from the port
  input wire logic rxc_in, // receive clock from the port
  input wire logic rxdv_in, // receive data valid
  input wire logic [3:0] rxd_in, // receive data
  input wire logic rxer_in, // receive error
  input wire logic junk_in, // drive non-zero data while idle
  input wire logic hold_in, // keep enable high with no data
  output logic tx_en_out, // transmit enable
  output logic [3:0] txd_out // transmit data
);
  logic [3:0] tx_q[$]; // nibbles waiting to go out
  logic [7:0] rx_q[$]; // bytes gathered from the port
  logic err_r = 1'b0; // error seen inside a frame
  logic txc_d_r = 1'b0; // last transmit clock level
  logic rxc_d_r = 1'b0; // last receive clock level
  logic [3:0] lo_r = 4'h0; // low nibble of the byte in progress
  logic half_r = 1'b0; // low nibble already held
  initial begin
    tx_en_out = 1'b0;
    txd_out = 4'h0;
  end
  // queue one byte, low nibble first
  function automatic void send(input logic [7:0] b);
    tx_q.push_back(b[3:0]);
    tx_q.push_back(b[7:4]);
  endfunction
  // pins change only just after a transmit clock rise
  always @(posedge sys_clk_in) begin
    txc_d_r <= txc_in;
    if (txc_in && !txc_d_r) begin
      if (tx_q.size() > 0) begin
        tx_en_out <= 1'b1; // held over every nibble
        txd_out <= tx_q.pop_front();
      end else begin
        tx_en_out <= hold_in; // dropped after the last nibble unless hold_in is high
        txd_out <= junk_in ? 4'($urandom_range(15, 1)) : 4'h0;
      end
    end
  end
  // one nibble per receive clock rise while valid
  always @(posedge sys_clk_in) begin
    rxc_d_r <= rxc_in;
    if (rxc_in && !rxc_d_r) begin
      if (rxdv_in === 1'b1) begin
        err_r <= err_r | (rxer_in === 1'b1); // error only counts inside valid
        if (half_r) rx_q.push_back({rxd_in, lo_r}); // high nibble second
        lo_r <= rxd_in;
        half_r <= !half_r;
      end else begin
        half_r <= 1'b0;
      end
    end
  end
endmodule

/* File: bench/mii_phy_port_tb.sv */
// self-checking bench for the nibble port against the mac model
`timescale 1ns/1ps
module mii_phy_port_tb;
  localparam int unsigned JAB = 1000; // shortened lockout, above one slow test frame
  localparam int unsigned REL = 2000; // shortened release time
  localparam int PF = mii_pkg::SYS_CLK_HZ / mii_pkg::CLK_FAST_HZ; // fast period
  localparam int PS = mii_pkg::SYS_CLK_HZ / mii_pkg::CLK_SLOW_HZ; // slow period
  logic clk = 1'b0; // system clock
  logic nrst = 1'b0; // reset, active low
  logic [2:0] strap = 3'h0; // strap pins
  logic spd = 1'b1; // speed select
  logic fd = 1'b1; // full duplex
  logic link = 1'b0; // link status
  logic rec_clk = 1'b0; // recovered line clock, 80 ns
  logic [7:0] rx_byte = 8'h00; // byte offered from the line
  logic rx_v = 1'b0; // byte offer
  logic sos = 1'b0, eos = 1'b0, idle = 1'b0, cerr = 1'b0; // line event pulses
  logic junk = 1'b0; // mac drives garbage while idle
  logic hold = 1'b0; // mac holds enable high
  logic mode, txc, tx_en, txv, rx_ready, rxc, rxdv, rxer, crs, col; // port signals
  logic [3:0] txd, rxd; // nibble buses
  logic [7:0] tx_byte; // byte toward the line coder
  logic [7:0] exp_q[$]; // expected bytes
  logic [7:0] tx_got[$]; // bytes seen toward the line coder
  int n_mismatch = 0;
  int total_checks = 0;
  int col_hits = 0; // cycles with collision high
  int cycles = 0; // run length guard
  mii_phy_port #(.JABBER_CYC(JAB), .RELEASE_CYC(REL)) DUT (
    .sys_clk_in(clk), .nrst_in(nrst), .ce_in(1'b1), .cfg_strap_in(strap),
    .speed_100_in(spd), .full_duplex_in(fd), .link_up_in(link), .mii_mode_out(mode),
    .txc_out(txc), .tx_en_in(tx_en), .txd_in(txd), .tx_byte_out(tx_byte),
    .tx_byte_valid_out(txv), .rec_clk_in(rec_clk), .rx_byte_in(rx_byte),
    .rx_byte_valid_in(rx_v), .rx_byte_ready_out(rx_ready), .rx_sos_in(sos),
    .rx_eos_in(eos), .rx_idle_in(idle), .rx_code_err_in(cerr), .rxc_out(rxc),
    .rxdv_out(rxdv), .rxd_out(rxd), .rxer_out(rxer), .crs_out(crs), .col_out(col));
  mac_model mac (
    .sys_clk_in(clk), .txc_in(txc), .rxc_in(rxc), .rxdv_in(rxdv), .rxd_in(rxd),
    .rxer_in(rxer), .junk_in(junk), .hold_in(hold), .tx_en_out(tx_en), .txd_out(txd));
  always #5 clk = ~clk;
  // line clock, phase offset so it never meets a system edge
  initial begin
    #3;
    forever #40 rec_clk = ~rec_clk;
  end
  // watch outputs and cut a hung run short
  always @(posedge clk) begin
    cycles++;
    if (txv === 1'b1) tx_got.push_back(tx_byte);
    if (col === 1'b1) col_hits++;
    if (cycles == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reset_dut();
    nrst <= 1'b0;
    cyc(8);
    nrst <= 1'b1;
    cyc(6);
  endtask
  // period of a port clock in system cycles, rise to rise
  task automatic measure(input bit rx, output int p);
    p = 0;
    do @(posedge clk); while ((rx ? rxc : txc) !== 1'b0);
    do @(posedge clk); while ((rx ? rxc : txc) !== 1'b1);
    do begin @(posedge clk); p++; end while ((rx ? rxc : txc) !== 1'b0);
    do begin @(posedge clk); p++; end while ((rx ? rxc : txc) !== 1'b1);
  endtask
  task automatic pulse(input logic [3:0] m);
    {sos, eos, idle, cerr} <= m;
    cyc(1);
    {sos, eos, idle, cerr} <= 4'h0;
    cyc(2);
  endtask
  task automatic cmp_q(input logic [7:0] g[$]);
    check(8'(g.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) if (i < g.size()) check(g[i], exp_q[i]);
  endtask
  // held offer, taken at the edge where ready is high
  task automatic offer(input logic [7:0] b);
    int n;
    n = 0;
    rx_v <= 1'b1;
    rx_byte <= b;
    do begin @(posedge clk); n++; end while (rx_ready !== 1'b1 && n < 400);
  endtask
  // one receive frame: preamble, delimiter, data with a coding error
  task automatic rx_frame(input bit fast);
    logic [7:0] b;
    exp_q.delete();
    mac.rx_q.delete();
    mac.err_r = 1'b0;
    pulse(4'h8);
    check(8'(crs), 8'h01); // start of stream raises carrier
    for (int k = 0; k < 8; k++) begin
      b = k < 2 ? 8'h55 : (k == 2 ? mii_pkg::SFD_BYTE : 8'($urandom));
      if (fast || k >= 2) exp_q.push_back(b);
      cerr <= (k == 4);
      offer(b);
    end
    cerr <= 1'b0;
    rx_v <= 1'b0;
    rx_byte <= ~b;
    cyc(80);
    cmp_q(mac.rx_q); // valid span per speed, nibble order
    check(8'(mac.err_r), 8'h01); // coding error flagged in frame
  endtask
  initial begin
    int p;
    logic [7:0] b;
    void'($urandom(57));
    reset_dut();
    check(8'(mode), 8'h01); // all-zero straps pick nibble mode
    strap <= 3'($urandom_range(7, 1));
    reset_dut();
    check(8'(mode), 8'h00); // other straps do not
    strap <= 3'h0;
    reset_dut();
    for (int s = 0; s < 2; s++) begin
      spd <= s[0];
      cyc(100);
      measure(0, p);
      check(8'(p), 8'(s ? PF : PS)); // transmit clock rate
      measure(1, p);
      check(8'(p), 8'(s ? PF : PS)); // reference while link down
    end
    link <= 1'b1;
    spd <= 1'b0;
    cyc(100);
    measure(1, p);
    check(8'(p), 8'(PS)); // slow idle line stays on reference
    spd <= 1'b1;
    cyc(100);
    measure(1, p);
    check(8'(p), 8'h08); // fast mode follows the line clock
    $display("test clocks done");
    junk <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      spd <= s[0];
      cyc(100);
      exp_q.delete();
      tx_got.delete();
      col_hits = 0;
      for (int k = 0; k < 6; k++) begin
        b = 8'($urandom);
        exp_q.push_back(b);
        mac.send(b);
      end
      cyc(s ? 200 : 900);
      cmp_q(tx_got); // whole bytes, idle junk ignored
      check(8'(col_hits), s ? 8'h00 : 8'(mii_pkg::SQE_CYC)); // heartbeat
    end
    $display("test transmit done");
    junk <= 1'b0;
    fd <= 1'b0;
    cyc(20);
    col_hits = 0;
    mac.send(8'h3c);
    rx_frame(1'b1);
    check(8'(col_hits != 0), 8'h01); // both directions active
    pulse(4'h2);
    check(8'(crs), 8'h00); // idle without end pair drops carrier
    fd <= 1'b1;
    spd <= 1'b0;
    cyc(100);
    rx_frame(1'b0);
    pulse(4'h2);
    check(8'(crs), 8'h01); // idle alone keeps slow carrier
    pulse(4'h4);
    check(8'(crs), 8'h00); // end marker drops carrier
    $display("test receive done");
    hold <= 1'b1;
    cyc(JAB + 200);
    check(8'(col), 8'h01); // long enable locks out
    hold <= 1'b0;
    cyc(REL / 2);
    check(8'(col), 8'h01); // lockout holds while quiet too short
    cyc(REL + 100);
    check(8'(col), 8'h00); // long quiet releases
    $display("test jabber done");
    complete_run();
  end
endmodule
